/* File: src/gpg_defs.vh */
// Register indices, field positions and reset values of the gate control
`ifndef GPG_DEFS_VH
`define GPG_DEFS_VH

// Register indices; byte address is four times the index
`define GPG_ACK_A_IDX      7'h02
`define GPG_ACK_B_IDX      7'h03
`define GPG_IN_STAT_IDX    7'h02
`define GPG_OUT_STAT_IDX   7'h03
`define GPG_CNT_STAT_IDX   7'h04
`define GPG_CMD0_IDX       7'h06
`define GPG_CMD1_IDX       7'h07
`define GPG_MODE0_IDX      7'h1a
`define GPG_MODE1_IDX      7'h1b
`define GPG_JOINT1_IDX     7'h1b
`define GPG_INSEL0_IDX     7'h24
`define GPG_INSEL1_IDX     7'h25
`define GPG_IRQ_EN_A_IDX   7'h49
`define GPG_SEC_EN_A_IDX   7'h4a
`define GPG_IRQ_EN_B_IDX   7'h4b
`define GPG_SEC_EN_B_IDX   7'h4c

// Command word fields
`define GPG_ARM_BIT        0
`define GPG_DISARM_BIT     4
`define GPG_DISARM_CP_BIT  15

// Acknowledge word fields
`define GPG_FCLR_A_BIT     5
`define GPG_FCLR_B_BIT     1
`define GPG_IRQ_CLR_BIT    15

// Enable word fields
`define GPG_EN_A_BIT       8
`define GPG_EN_B_BIT       10

// Status fields (counter 0; counter 1 is one higher, but its irq bit is bit 2 of the output side word)
`define GPG_COUNTING_BIT   2
`define GPG_ARMED_BIT      8
`define GPG_FAULT_BIT      14
`define GPG_IRQ_ST_BIT     2
`define GPG_GATE_ST_BIT    2

// Mode word fields
`define GPG_MODE_LSB       0
`define GPG_DUAL_BIT       2
`define GPG_INVERT_BIT     13
`define GPG_MODE_OFF       2'h0
`define GPG_MODE_LEVEL     2'h1
`define GPG_MODE_EDGE_A    2'h2
`define GPG_MODE_EDGE_B    2'h3

// Input select fields
`define GPG_SRC_LSB        7
`define GPG_PRESET_BIT     12

// Reset values
`define GPG_WORD_RST       16'h0000

`endif

/* File: src/gpg_gate_ctrl.v */
// Gate control and status for two general-purpose counters, APB slave
//
// Operation
// - Counting status shows, while armed, whether a counter counts.
// - Disarm strobe or its copy in the other command word disarms.
// - A gate acknowledge latency error sets a sticky fault flag.
// - The fault clear strobe in the acknowledge word clears that flag.
// - Gate irq clear strobe clears the gate irq flag and its request.
// - Primary gate irq enable gates the request in the primary bank.
// - Irq on stop edge for level gating, every start edge for edge.
// - Secondary enable routes the same request to the second bank.
// - Gate irq flag reads in the input side status word for counter 0, output side for counter 1.
// - Dual edge mode bit makes both gate edges act.
// - Gate invert bit turns the gate to active low before use.
// - Five-bit source field picks pin, trigger or internal signal.
// - Under level gating, level picks preset: active selects A, inactive selects B.
// - Gate level flag shows the gate after polarity.
// - Gating mode field: off, level, or edge on opposite edges.
// - Arm strobe arms the counter until it is disarmed.
`timescale 1ns/1ns
`include "gpg_defs.vh"

module gpg_gate_ctrl (
  // Clock, reset, enable
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  // Gate sources from pins and other domains
  input  wire [9:0]  programmable_function_pin,
  input  wire [6:0]  system_sync_trigger_line,
  input  wire        acquisition_second_start,
  input  wire        update_two_terminal_count,
  input  wire        acquisition_first_start,
  // Counter core, same clock
  input  wire [1:0]  counter_terminal_count,
  input  wire [1:0]  gate_ack_late,
  input  wire [1:0]  hw_disarm,
  input  wire [1:0]  next_load_b,
  // Counter state out
  output wire [1:0]  armed_flag,
  output wire [1:0]  counting_flag,
  output wire [1:0]  gate_level_flag,
  output wire [1:0]  gate_event,
  output wire [1:0]  load_sel_b,
  output wire [1:0]  gate_irq_primary,
  output wire [1:0]  gate_irq_secondary
);

  // Gate multiplexer; unused codes and code 31 give a low gate
  function src_pick;
    input [4:0]  sel;
    input [19:0] ext;
    input        other_tc;
    begin
      if (sel >= 5'h01 && sel <= 5'h11) begin
        src_pick = ext[sel - 5'h01];
      end else if (sel == 5'h12) begin
        src_pick = ext[17];
      end else if (sel == 5'h13) begin
        src_pick = ext[18];
      end else if (sel == 5'h14) begin
        src_pick = other_tc;
      end else if (sel == 5'h15) begin
        src_pick = ext[19];
      end else begin
        src_pick = 1'b0;
      end
    end
  endfunction

  // Stored configuration
  reg  [31:0] mode_q;
  reg  [31:0] insel_q;
  reg  [1:0]  en_pri_q;
  reg  [1:0]  en_sec_q;
  // Bus phase tracking
  reg         taken_q;
  // Source synchroniser
  reg  [19:0] meta_q;
  reg  [19:0] sync_q;

  wire [6:0]  idx;
  wire        aligned;
  wire        wr_go;
  wire [15:0] wd;
  wire        wr_cmd0;
  wire        wr_cmd1;
  wire        wr_ack_a;
  wire        wr_ack_b;
  wire [1:0]  arm_stb;
  wire [1:0]  disarm_stb;
  wire [1:0]  fault_clr;
  wire [1:0]  irq_clr;
  wire [1:0]  fault_flag;
  wire [1:0]  irq_flag;
  reg         hit;
  reg  [15:0] rd_word;

  assign idx     = paddr[8:2];
  assign aligned = (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0);
  assign wd      = pwdata[15:0];

  // Ready only once the setup phase was seen with the clock enabled,
  // so a frozen block stretches the access instead of losing it
  assign pready  = ce & taken_q;
  assign wr_go   = psel & penable & pready & pwrite & aligned;

  assign wr_cmd0  = wr_go && (idx == `GPG_CMD0_IDX);
  assign wr_cmd1  = wr_go && (idx == `GPG_CMD1_IDX);
  assign wr_ack_a = wr_go && (idx == `GPG_ACK_A_IDX);
  assign wr_ack_b = wr_go && (idx == `GPG_ACK_B_IDX);

  // Strobes live one cycle and are never stored
  assign arm_stb[0]    = wr_cmd0 & wd[`GPG_ARM_BIT];
  assign arm_stb[1]    = wr_cmd1 & wd[`GPG_ARM_BIT];
  assign disarm_stb[0] = (wr_cmd0 & wd[`GPG_DISARM_BIT])
                       | (wr_cmd1 & wd[`GPG_DISARM_CP_BIT]);
  assign disarm_stb[1] = (wr_cmd1 & wd[`GPG_DISARM_BIT])
                       | (wr_cmd0 & wd[`GPG_DISARM_CP_BIT]);
  assign fault_clr[0]  = wr_ack_a & wd[`GPG_FCLR_A_BIT];
  assign fault_clr[1]  = wr_ack_b & wd[`GPG_FCLR_B_BIT];
  assign irq_clr[0]    = wr_ack_a & wd[`GPG_IRQ_CLR_BIT];
  assign irq_clr[1]    = wr_ack_b & wd[`GPG_IRQ_CLR_BIT];

  // Two flops on every source that comes from outside this clock;
  // only the second rank is read, the first may still be settling
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 20'h00000;
      sync_q <= 20'h00000;
    end else if (ce) begin
      meta_q <= {acquisition_first_start, update_two_terminal_count,
                 acquisition_second_start, system_sync_trigger_line,
                 programmable_function_pin};
      sync_q <= meta_q;
    end
  end

  // Configuration writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q   <= {`GPG_WORD_RST, `GPG_WORD_RST};
      insel_q  <= {`GPG_WORD_RST, `GPG_WORD_RST};
      en_pri_q <= 2'h0;
      en_sec_q <= 2'h0;
    end else if (wr_go) begin
      case (idx)
        `GPG_MODE0_IDX:    mode_q[15:0]   <= wd;
        `GPG_MODE1_IDX:    mode_q[31:16]  <= wd;
        `GPG_INSEL0_IDX:   insel_q[15:0]  <= wd;
        `GPG_INSEL1_IDX:   insel_q[31:16] <= wd;
        `GPG_IRQ_EN_A_IDX: en_pri_q[0] <= wd[`GPG_EN_A_BIT];
        `GPG_IRQ_EN_B_IDX: en_pri_q[1] <= wd[`GPG_EN_B_BIT];
        `GPG_SEC_EN_A_IDX: en_sec_q[0] <= wd[`GPG_EN_A_BIT];
        `GPG_SEC_EN_B_IDX: en_sec_q[1] <= wd[`GPG_EN_B_BIT];
        default: ;
      endcase
    end
  end

  // Read decode; write-only words read as zero
  // Mode word 1 shares its index with the joint status, which wins
  always @* begin
    hit     = 1'b1;
    rd_word = 16'h0000;
    case (idx)
      `GPG_IN_STAT_IDX:
        rd_word[`GPG_IRQ_ST_BIT] = irq_flag[0];
      `GPG_OUT_STAT_IDX:
        rd_word[`GPG_IRQ_ST_BIT] = irq_flag[1];
      `GPG_CNT_STAT_IDX: begin
        rd_word[`GPG_COUNTING_BIT +: 2] = counting_flag;
        rd_word[`GPG_ARMED_BIT +: 2]    = armed_flag;
        rd_word[`GPG_FAULT_BIT +: 2]    = fault_flag;
      end
      `GPG_JOINT1_IDX:
        rd_word[`GPG_GATE_ST_BIT +: 2] = gate_level_flag;
      `GPG_CMD0_IDX, `GPG_CMD1_IDX, `GPG_MODE0_IDX,
      `GPG_INSEL0_IDX, `GPG_INSEL1_IDX, `GPG_IRQ_EN_A_IDX,
      `GPG_SEC_EN_A_IDX, `GPG_IRQ_EN_B_IDX, `GPG_SEC_EN_B_IDX:
        rd_word = 16'h0000;
      default:
        hit = 1'b0;
    endcase
    if (!aligned) begin
      hit = 1'b0;
    end
  end

  // Bus answer is captured in the setup phase and shown in the access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taken_q <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      // A setup cycle that fell while frozen is caught up in the access
      // phase; keying on penable alone would leave that access hanging
      if (psel && !taken_q) begin
        taken_q <= 1'b1;
        prdata  <= pwrite ? 32'h00000000 : {16'h0000, rd_word};
        pslverr <= ~hit;
      end else if (psel && penable) begin
        taken_q <= 1'b0;
      end
    end
  end

  // Per-counter gate logic
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gc
      wire [15:0] md;
      wire [1:0]  gmode;
      wire        dual;
      wire        raw;
      wire        act;
      wire        rise;
      wire        fall;
      wire        lvl;
      wire        edg;
      wire        start_ev;
      wire        stop_ev;
      wire        irq_ev;
      reg         prev_q;
      reg         armed_q;
      reg         run_q;
      reg         fault_q;
      reg         irq_q;

      assign md    = mode_q[16*g +: 16];
      assign gmode = md[`GPG_MODE_LSB +: 2];
      assign dual  = md[`GPG_DUAL_BIT];
      assign raw   = src_pick(insel_q[16*g + `GPG_SRC_LSB +: 5], sync_q,
                              counter_terminal_count[1-g]);
      assign act   = raw ^ md[`GPG_INVERT_BIT];
      assign rise  = act & ~prev_q;
      assign fall  = ~act & prev_q;
      assign lvl   = (gmode == `GPG_MODE_LEVEL);
      assign edg   = (gmode == `GPG_MODE_EDGE_A)
                   | (gmode == `GPG_MODE_EDGE_B);

      // Edge mode A starts on the active-going edge, mode B on the
      // opposite one; invert already folded into act
      assign start_ev = lvl ? rise
                      : (gmode == `GPG_MODE_EDGE_A) ? rise : fall;
      assign stop_ev  = lvl ? fall
                      : (gmode == `GPG_MODE_EDGE_A) ? fall : rise;

      // Stop edge under level gating, start edge under edge gating,
      // and the other edge too when dual-edge is on
      assign irq_ev = lvl ? (stop_ev | (dual & start_ev))
                    : edg ? (start_ev | (dual & stop_ev))
                    : 1'b0;

      // Gate edge history; resets to the idle low level of the gate so
      // no false edge shows right after reset with default polarity
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prev_q <= 1'b0;
        end else if (ce) begin
          prev_q <= act;
        end
      end

      // Arm state; a disarm in the same write as an arm wins, so a
      // mixed write can never leave a counter armed
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          armed_q <= 1'b0;
        end else if (ce) begin
          if (disarm_stb[g] || hw_disarm[g]) begin
            armed_q <= 1'b0;
          end else if (arm_stb[g]) begin
            armed_q <= 1'b1;
          end
        end
      end

      // Edge gating run state: start edge runs, stop edge halts only
      // when dual-edge is on; single-edge keeps running once started
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          run_q <= 1'b0;
        end else if (ce) begin
          if (!armed_q) begin
            run_q <= 1'b0;
          end else if (edg && start_ev) begin
            run_q <= 1'b1;
          end else if (edg && dual && stop_ev) begin
            run_q <= 1'b0;
          end
        end
      end

      // Sticky flags; a new event beats a clear in the same cycle,
      // so an event in the clearing cycle is never lost
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fault_q <= 1'b0;
          irq_q   <= 1'b0;
        end else if (ce) begin
          if (gate_ack_late[g]) begin
            fault_q <= 1'b1;
          end else if (fault_clr[g]) begin
            fault_q <= 1'b0;
          end
          if (irq_ev) begin
            irq_q <= 1'b1;
          end else if (irq_clr[g]) begin
            irq_q <= 1'b0;
          end
        end
      end

      assign armed_flag[g]      = armed_q;
      // Level gating counts while active; with gating off it always runs
      assign counting_flag[g]   = armed_q & (lvl ? act
                                : edg ? run_q : 1'b1);
      assign gate_level_flag[g] = act;
      // Qualified by the enable so a frozen block shows each event once
      assign gate_event[g]      = irq_ev & ce;
      assign fault_flag[g]      = fault_q;
      assign irq_flag[g]        = irq_q;
      // Gate level chooses the preset only under level gating; the
      // alternation from the core is then overridden
      assign load_sel_b[g] = (lvl & insel_q[16*g + `GPG_PRESET_BIT])
                           ? ~act : next_load_b[g];
      assign gate_irq_primary[g]   = irq_q & en_pri_q[g];
      assign gate_irq_secondary[g] = irq_q & en_sec_q[g];
    end
  endgenerate

endmodule // gpg_gate_ctrl

/* File: test/gpg_gate_ctrl_props.sv */
// Concurrent checks on the gate control ports
`timescale 1ns/1ns
module gpg_props (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // APB request
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire        pready,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  // Counter state
  input wire [1:0]  armed_flag,
  input wire [1:0]  gate_event,
  input wire [1:0]  gate_irq_primary,
  input wire [1:0]  gate_irq_secondary
);
  // Write taken at this edge
  wire wr = psel & penable & pready & pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_arm;
    $rose(armed_flag[1]) |-> $past(wr && paddr == 12'h01c && pwdata[0]);
  endproperty
  a_arm: assert property (p_arm) else $error("arm unprompted");
  property p_dis;
    wr && paddr == 12'h018 && pwdata[4] |=> !armed_flag[0];
  endproperty
  a_dis: assert property (p_dis) else $error("disarm lost");
  property p_cpy;
    wr && paddr == 12'h018 && pwdata[15] |=> !armed_flag[1];
  endproperty
  a_cpy: assert property (p_cpy) else $error("copy lost");
  property p_ack;
    wr && paddr == 12'h008 && pwdata[15] && !gate_event[0]
      |=> !gate_irq_primary[0];
  endproperty
  a_ack: assert property (p_ack) else $error("ack lost");
  // A request may only follow a gate edge or an enable write
  property p_rise;
    $rose(gate_irq_primary[0])
      |-> $past(gate_event[0] || wr && paddr == 12'h124);
  endproperty
  a_rise: assert property (p_rise) else $error("stray irq");
  property p_en;
    wr && paddr == 12'h124 && !pwdata[8] |=> !gate_irq_primary[0];
  endproperty
  a_en: assert property (p_en) else $error("enable ignored");
  property p_sec;
    wr && paddr == 12'h130 && !pwdata[10] |=> !gate_irq_secondary[1];
  endproperty
  a_sec: assert property (p_sec) else $error("second enable");
  property p_evt;
    gate_event[0] |=> !gate_event[0];
  endproperty
  a_evt: assert property (p_evt) else $error("event too long");
endmodule // gpg_props

bind gpg_gate_ctrl gpg_props gpg_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
  .armed_flag(armed_flag), .gate_event(gate_event),
  .gate_irq_primary(gate_irq_primary),
  .gate_irq_secondary(gate_irq_secondary));

/* File: test/gpg_src_model.sv */
// Far-side gate sources: the selected line follows the bench
`timescale 1ns/1ns
module gpg_src_model (
  // Clock and bench control
  input  wire       pclk,
  input  wire [4:0] code,
  input  wire       lvl,
  // Gate sources
  output wire [9:0] pin,
  output wire [6:0] trig,
  output wire       st2,
  output wire       upd,
  output wire       st1,
  output wire [1:0] tc
);
  reg         wig_q = 1'b0;
  wire [21:0] hit = 22'h1 << code;
  wire [21:0] v   = (hit & {22{lvl}}) | (~hit & {22{wig_q}});
  // Unselected lines wiggle, so a wrong select shows as a wrong gate
  always @(posedge pclk) wig_q <= ~wig_q;
  // Codes 1-10 pins, 11-17 triggers, 18-21 internal lines
  assign pin  = v[10:1];
  assign trig = v[17:11];
  assign st2  = v[18];
  assign upd  = v[19];
  assign tc   = {v[20], wig_q};
  assign st1  = v[21];
endmodule // gpg_src_model

/* File: test/tb.sv */
// Self-checking bench for the gate control block
`timescale 1ns/1ns
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
  n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); \
  end end
module tb;
  reg         pclk    = 1'b0;
  reg         presetn = 1'b0;
  reg         ce      = 1'b1;
  reg         psel    = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite  = 1'b0;
  reg  [11:0] paddr   = 12'h000;
  reg  [31:0] pwdata  = 32'h0000_0000;
  reg  [1:0]  late    = 2'h0;
  reg  [1:0]  hwd     = 2'h0;
  reg  [1:0]  nlb     = 2'h0;
  reg  [4:0]  code    = 5'h00;
  reg         lvl     = 1'b0;
  reg  [31:0] rd;
  reg         err;
  wire [31:0] prdata;
  wire        pready, pslverr, st2, upd, st1;
  wire [9:0]  pin;
  wire [6:0]  trig;
  wire [1:0]  tc, armed, cnt, glev, gev, lsb, irqp, irqs;
  int         n_mismatch = 0;
  int         checks_done = 0;
  int         arm [2] = '{0, 0};
  int         flt [2] = '{0, 0};

  always #10 pclk = ~pclk;

  gpg_src_model gpg_src_model_inst (.pclk(pclk), .code(code), .lvl(lvl),
    .pin(pin), .trig(trig), .st2(st2), .upd(upd), .st1(st1), .tc(tc));

  gpg_gate_ctrl gpg_gate_ctrl_inst (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .programmable_function_pin(pin),
    .system_sync_trigger_line(trig), .acquisition_second_start(st2),
    .update_two_terminal_count(upd), .acquisition_first_start(st1),
    .counter_terminal_count(tc), .gate_ack_late(late), .hw_disarm(hwd),
    .next_load_b(nlb), .armed_flag(armed), .counting_flag(cnt),
    .gate_level_flag(glev), .gate_event(gev), .load_sel_b(lsb),
    .gate_irq_primary(irqp), .gate_irq_secondary(irqs));

  // Expected counter status word; gating is off while it is used
  function automatic [31:0] st();
    st = (arm[0] << 2) | (arm[1] << 3) | (arm[0] << 8) | (arm[1] << 9) |
         (flt[0] << 14) | (flt[1] << 15);
  endfunction

  // One APB transfer; pready and read data are taken at one rising
  // edge, and the task returns an edge later so effects have settled
  task automatic apb(input bit w, input [11:0] a, input [15:0] d);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'($urandom), d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 40) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 40) n_mismatch++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input [11:0] a, input [31:0] e, input string n);
    apb(1'b0, a, 16'h0000);
    `CHK(n, e, rd)
  endtask

  // Gate level change, then room for the two-flop sync and the flag
  task automatic gwait(input bit l);
    lvl <= l;
    repeat (5) @(posedge pclk);
  endtask

  task stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard, far beyond the under one thousand cycles the run needs
  initial begin
    #400000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    void'($urandom(3));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(12'h010, 32'h0, "status");
    rchk(12'h018, 32'h0, "write-only");
    apb(1'b0, 12'h1fc, 16'h0000);
    `CHK("unmapped", 1'b1, err)
    $display("test map done");
    // Arm both, then disarm by copies, own strobe and hardware
    apb(1'b1, 12'h018, 16'h0001);
    apb(1'b1, 12'h01c, 16'h0001);
    arm = '{1, 1};
    rchk(12'h010, st(), "armed");
    `CHK("counting", 2'h3, cnt)
    apb(1'b1, 12'h018, 16'h0000);
    rchk(12'h010, st(), "zero write");
    apb(1'b1, 12'h018, 16'h8000);
    arm[1] = 0;
    rchk(12'h010, st(), "copy 1");
    apb(1'b1, 12'h01c, 16'h8000);
    arm[0] = 0;
    rchk(12'h010, st(), "copy 0");
    apb(1'b1, 12'h018, 16'h0011);
    rchk(12'h010, st(), "disarm wins");
    apb(1'b1, 12'h01c, 16'h0001);
    hwd <= 2'h2;
    @(posedge pclk);
    hwd <= 2'h0;
    ce  <= 1'b0;
    fork
      begin
        repeat (4) @(posedge pclk);
        ce <= 1'b1;
      end
    join_none
    rchk(12'h010, st(), "hw disarm");
    $display("test arming done");
    for (int g = 0; g < 2; g++) begin
      late <= 2'(1 << g);
      @(posedge pclk);
      late <= 2'h0;
      flt[g] = 1;
      rchk(12'h010, st(), "fault set");
      apb(1'b1, 12'(8 + 4 * g), g ? 16'h0002 : 16'h0020);
      flt[g] = 0;
      rchk(12'h010, st(), "fault clear");
    end
    $display("test fault done");
    // Level gating on counter 0 across every source code
    apb(1'b1, 12'h068, 16'h0001);
    apb(1'b1, 12'h124, 16'h0100);
    apb(1'b1, 12'h018, 16'h0001);
    for (int c = 1; c < 32; c++) begin
      if (c > 21 && c < 31) continue;
      apb(1'b1, 12'h090, 16'(c << 7));
      code <= 5'(c);
      gwait(1'b0);
      apb(1'b1, 12'h008, 16'h8000);
      gwait(1'b1);
      `CHK("gate high", c != 31, glev[0])
      `CHK("counting gate", c != 31, cnt[0])
      `CHK("no start irq", 1'b0, irqp[0])
      gwait(1'b0);
      `CHK("stop irq", c != 31, irqp[0])
      rchk(12'h008, c != 31 ? 32'h4 : 32'h0, "in status");
      apb(1'b1, 12'h008, 16'h8000);
      `CHK("irq ack", 1'b0, irqp[0])
    end
    // Inverted gate drives level flag and preset choice
    nlb <= 2'($urandom);
    code <= 5'd1;
    apb(1'b1, 12'h090, 16'h1080);
    apb(1'b1, 12'h068, 16'h2001);
    gwait(1'b0);
    `CHK("inverted", 1'b1, glev[0])
    `CHK("preset a", 1'b0, lsb[0])
    `CHK("alternation", nlb[1], lsb[1])
    rchk(12'h06c, 32'h4, "gate status");
    gwait(1'b1);
    `CHK("preset b", 1'b1, lsb[0])
    // Edge gating on counter 1 raises the secondary request on start
    code <= 5'd2;
    gwait(1'b0);
    apb(1'b1, 12'h094, 16'h0100);
    apb(1'b1, 12'h06c, 16'h0002);
    apb(1'b1, 12'h01c, 16'h0001);
    apb(1'b1, 12'h130, 16'h0400);
    apb(1'b1, 12'h00c, 16'h8000);
    `CHK("sec idle", 1'b0, irqs[1])
    gwait(1'b1);
    `CHK("sec edge", 1'b1, irqs[1])
    `CHK("prim off", 1'b0, irqp[1])
    rchk(12'h00c, 32'h4, "out status");
    apb(1'b1, 12'h130, 16'h0000);
    `CHK("sec off", 1'b0, irqs[1])
    apb(1'b1, 12'h124, 16'h0000);
    `CHK("prim masked", 1'b0, irqp[0])
    // Dual-edge mode 3 on counter 1: fall starts, rise stops
    `CHK("edge run", 1'b1, cnt[1])
    apb(1'b1, 12'h06c, 16'h0007);
    apb(1'b1, 12'h12c, 16'h0400);
    apb(1'b1, 12'h00c, 16'h8000);
    `CHK("dual idle", 1'b0, irqp[1])
    gwait(1'b0);
    `CHK("dual start", 1'b1, irqp[1])
    `CHK("dual run", 1'b1, cnt[1])
    apb(1'b1, 12'h00c, 16'h8000);
    gwait(1'b1);
    `CHK("dual stop", 1'b1, irqp[1])
    `CHK("dual halt", 1'b0, cnt[1])
    $display("test gating done");
    stop_test();
  end
endmodule // tb
